// ### rtl/servo_status_output_logic.sv
/*
  Servo status output logic: derives seven status flags from control
  state and settings, and routes any of them to four output terminals.
  Assumes all inputs are synchronous to ref_clk_in and that settings
  are held steady by the control firmware.
*/
// Operation
// RL1: Speed match flag set when absolute speed error is within match width.
// RL2: Each warning output follows its own warning selection setting.
// RL3: Position command output high while a positioning command is received.
// RL4: Speed clamp output high in torque mode or under speed limit.
// RL5: Fault clearable flag high when an alarm occurred or is clearable.
// RL6: Speed command output high in speed mode or with speed command.
// RL7: No terminal driven by default; routing only via four selections.
// RL8: All evaluated on control clock; all outputs inactive during reset.
`timescale 1ns/1ps
`default_nettype none
module servo_status_output_logic (
  input  wire logic                                      ref_clk_in,
  input  wire logic                                      arst_n_in,
  input  wire logic signed [status_out_pkg::SPEED_W-1:0] speed_cmd_in,
  input  wire logic signed [status_out_pkg::SPEED_W-1:0] speed_meas_in,
  input  wire logic [status_out_pkg::WIDTH_W-1:0]        speed_match_width_in,
  input  wire logic [status_out_pkg::WARN_SRC_W-1:0]     warn_cond_in,
  input  wire logic [status_out_pkg::WARN_SEL_W-1:0]     warning_select_a_in,
  input  wire logic [status_out_pkg::WARN_SEL_W-1:0]     warning_select_b_in,
  input  wire logic                                      pos_cmd_rx_in,
  input  wire logic                                      torque_mode_in,
  input  wire logic                                      speed_limit_in,
  input  wire logic                                      alarm_occurred_in,
  input  wire logic                                      alarm_clearable_in,
  input  wire logic                                      speed_mode_in,
  input  wire logic                                      speed_cmd_act_in,
  input  wire logic [status_out_pkg::SEL_W-1:0]          output_select_first_in,
  input  wire logic [status_out_pkg::SEL_W-1:0]          output_select_2_in,
  input  wire logic [status_out_pkg::SEL_W-1:0]          output_select_3_in,
  input  wire logic [status_out_pkg::SEL_W-1:0]          output_select_last_in,
  output logic                                           speed_match_flag_out,
  output logic                                           warning_out_a_out,
  output logic                                           warning_out_b_out,
  output logic                                           pos_cmd_active_out,
  output logic                                           speed_clamp_out,
  output logic                                           fault_clearable_flag_out,
  output logic                                           speed_cmd_active_out,
  output logic [status_out_pkg::TERM_N-1:0]              terminal_out
);
  import status_out_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic              vmatch;
    logic              warn_a;
    logic              warn_b;
    logic              pcmd;
    logic              vclamp;
    logic              fclr;
    logic              vcmd;
    logic [TERM_N-1:0] term;
  } state_t;

  state_t st;
  state_t next_st;

  logic [SPEED_W:0]       diff;
  logic [SPEED_W:0]       abs_diff;
  logic                   in_window;
  logic                   warn_a_pick;
  logic                   warn_b_pick;
  logic [SRC_N-1:0]       src;
  logic [SEL_W-1:0]       sel [TERM_N];

  // ****************************************************************
  // Speed error and condition picks
  // ****************************************************************
  // Widen before subtracting so the error never overflows
  assign diff = 17'({speed_cmd_in[SPEED_W-1], speed_cmd_in}
                  - {speed_meas_in[SPEED_W-1], speed_meas_in});
  // Two's complement negate; the widest error still fits in 17 bits
  assign abs_diff = diff[SPEED_W] ? 17'(~diff + 17'h1) : diff;
  // Window edge counts as a match, so the compare is inclusive
  assign in_window = abs_diff <= {1'h0, speed_match_width_in};

  // One picker per warning output; the 4-bit index covers all 16 bits,
  // so no setting can point past the condition vector
  assign warn_a_pick = warn_cond_in[warning_select_a_in];
  assign warn_b_pick = warn_cond_in[warning_select_b_in];

  // Selections gathered so one loop serves all four terminals
  assign sel[0] = output_select_first_in;
  assign sel[1] = output_select_2_in;
  assign sel[2] = output_select_3_in;
  assign sel[3] = output_select_last_in;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Terminals use this cycle's flags so routing adds no extra cycle
  always_comb begin
    next_st        = st;
    next_st.vmatch = in_window;                                // RL1
    next_st.warn_a = warn_a_pick;                              // RL2
    next_st.warn_b = warn_b_pick;                              // RL2
    next_st.pcmd   = pos_cmd_rx_in;                            // RL3
    next_st.vclamp = torque_mode_in | speed_limit_in;          // RL4
    next_st.fclr   = alarm_occurred_in | alarm_clearable_in;   // RL5
    next_st.vcmd   = speed_mode_in | speed_cmd_act_in;         // RL6
    src = {next_st.vcmd, next_st.fclr, next_st.vclamp, next_st.pcmd,
           next_st.warn_b, next_st.warn_a, next_st.vmatch, 1'b0};
    // Code zero selects nothing, so an unset terminal stays off
    for (int i = 0; i < TERM_N; i++) begin
      next_st.term[i] = src[sel[i]]; // RL7
    end
  end

  // Registered state, cleared under reset
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= {$bits(state_t){RST_LEVEL}}; // RL8
    end else begin
      st <= next_st; // RL8
    end
  end

  assign speed_match_flag_out     = st.vmatch;
  assign warning_out_a_out        = st.warn_a;
  assign warning_out_b_out        = st.warn_b;
  assign pos_cmd_active_out       = st.pcmd;
  assign speed_clamp_out          = st.vclamp;
  assign fault_clearable_flag_out = st.fclr;
  assign speed_cmd_active_out     = st.vcmd;
  assign terminal_out             = st.term;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Every check but the last is quiet while reset is low
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  // Speed error inside the configured match window this cycle
  sequence s_in_window;
    in_window;
  endsequence

  // Speed error beyond the window by at least one unit
  sequence s_out_window;
    !in_window;
  endsequence

  // Previous edge also ran out of reset; right after a release the
  // sampled history still comes from the last cycle spent in reset
  sequence s_run_prev;
    $past(arst_n_in);
  endsequence

  // Match flag follows the window one cycle later, set and clear
  a_speed_match_set: assert property (s_in_window |=> speed_match_flag_out) // RL1
    else $error("speed match flag missing");
  a_speed_match_clr: assert property (s_out_window |=> !speed_match_flag_out) // RL1
    else $error("speed match flag spurious");

  // Warning outputs follow the condition bit that their own setting picks
  a_warn_a_follow: assert property ( // RL2
    s_run_prev |-> warning_out_a_out == $past(warn_a_pick))
    else $error("warning a wrong");
  a_warn_b_follow: assert property ( // RL2
    s_run_prev |-> warning_out_b_out == $past(warn_b_pick))
    else $error("warning b wrong");

  // Position command output tracks the receive level both ways
  a_pos_cmd_track: assert property (pos_cmd_rx_in |=> pos_cmd_active_out) // RL3
    else $error("position command not shown");
  a_pos_cmd_drop: assert property (!pos_cmd_rx_in |=> !pos_cmd_active_out) // RL3
    else $error("position command held too long");

  // Clamp only with a cause, and always when a cause is present
  a_clamp_cause: assert property ( // RL4
    speed_clamp_out |-> $past(torque_mode_in) || $past(speed_limit_in))
    else $error("speed clamp without cause");
  a_clamp_set: assert property ( // RL4
    (torque_mode_in || speed_limit_in) |=> speed_clamp_out)
    else $error("speed clamp missing");

  // Fault clearable flag is a plain OR of its two causes
  a_fault_clr_set: assert property ( // RL5
    (alarm_occurred_in || alarm_clearable_in) |=> fault_clearable_flag_out)
    else $error("fault clearable missing");
  a_fault_clr_drop: assert property ( // RL5
    !(alarm_occurred_in || alarm_clearable_in) |=> !fault_clearable_flag_out)
    else $error("fault clearable spurious");

  // Speed command output equals its causes one cycle earlier
  a_speed_cmd_ok: assert property ( // RL6
    s_run_prev |-> speed_cmd_active_out == ($past(speed_mode_in) || $past(speed_cmd_act_in)))
    else $error("speed command output wrong");

  // Terminals carry the chosen cause of the same cycle as the flags;
  // checked against the inputs so a wrong source index shows up
  a_term_none: assert property ( // RL7
    (output_select_first_in == SEL_NONE) |=> !terminal_out[0])
    else $error("unselected terminal driven");
  a_term_route: assert property ( // RL7
    (output_select_last_in == SEL_PCMD) |=> terminal_out[3] == $past(pos_cmd_rx_in))
    else $error("terminal routing wrong");
  a_term_window: assert property ( // RL7
    (output_select_2_in == SEL_VMATCH) |=> terminal_out[1] == $past(in_window))
    else $error("terminal match routing wrong");
  a_term_clamp: assert property ( // RL7
    (output_select_3_in == SEL_VCLAMP)
    |=> terminal_out[2] == ($past(torque_mode_in) || $past(speed_limit_in)))
    else $error("terminal clamp routing wrong");

  // Reset clears every output without waiting for a clock edge
  a_reset_idle: assert property (@(posedge ref_clk_in) disable iff (1'b0) // RL8
    !arst_n_in |-> {speed_match_flag_out, warning_out_a_out, warning_out_b_out,
                    pos_cmd_active_out, speed_clamp_out, fault_clearable_flag_out,
                    speed_cmd_active_out, terminal_out} == '0)
    else $error("outputs active in reset");
endmodule
`default_nettype wire

// ### rtl/status_out_pkg.sv
/*
  Constants for the servo status output block: signal codes for the
  output selections, widths and reset values.
  Assumes a single control clock; no timing counts are needed.
*/
package status_out_pkg;
  // Speed values are signed, in drive speed units
  localparam int SPEED_W       = 16;
  localparam int WIDTH_W       = 16;
  localparam int WARN_SEL_W    = 4;
  localparam int WARN_SRC_W    = 16;
  localparam int SEL_W         = 3;
  localparam int TERM_N        = 4;
  localparam int SRC_N         = 8;

  // Codes for the output selection settings
  localparam logic [SEL_W-1:0] SEL_NONE   = 3'h0;
  localparam logic [SEL_W-1:0] SEL_VMATCH = 3'h1;
  localparam logic [SEL_W-1:0] SEL_WARN_A = 3'h2;
  localparam logic [SEL_W-1:0] SEL_WARN_B = 3'h3;
  localparam logic [SEL_W-1:0] SEL_PCMD   = 3'h4;
  localparam logic [SEL_W-1:0] SEL_VCLAMP = 3'h5;
  localparam logic [SEL_W-1:0] SEL_FCLR   = 3'h6;
  localparam logic [SEL_W-1:0] SEL_VCMD   = 3'h7;

  // Reset value of every status and terminal bit
  localparam logic RST_LEVEL = 1'b0;
endpackage

// ### testbench/servo_status_output_logic_tb_top.sv
/*
  Bench for the status output block: random control state and selections,
  expected flags queued by the driver, compared by a watching process.
  Assumes one-cycle registered outputs and an active-low async reset.
*/
`timescale 1ns/1ps
`default_nettype none
module servo_status_output_logic_tb_top;
  import status_out_pkg::*;
  // ****************************************
  // Stimulus, model of the outputs, checking
  // ****************************************
  logic                      ref_clk_in = 1'b0;
  logic                      arst_n_in  = 1'b1;
  logic signed [SPEED_W-1:0] cmd = '0, meas = '0;
  logic [WIDTH_W-1:0]        width = '0;
  logic [WARN_SRC_W-1:0]     cond = '0;
  logic [WARN_SEL_W-1:0]     sel_a = '0, sel_b = '0;
  logic [6:0]                bits = '0;
  logic [SEL_W-1:0]          osel [4] = '{default: '0};
  wire  [6:0]                fl;
  wire  [3:0]                term;
  wire  [3:0]                host_seen;
  logic [3:0]                host_exp = 4'h0;
  logic [10:0]               note;
  logic [10:0]               q [$];
  int                        seed = 50, n_fail = 0, compares = 0, cycles = 0;
  wire  [10:0]               got = {fl, term};
  servo_status_output_logic i_servo_status_output_logic (.ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in), .speed_cmd_in(cmd), .speed_meas_in(meas),
    .speed_match_width_in(width), .warn_cond_in(cond), .warning_select_a_in(sel_a),
    .warning_select_b_in(sel_b), .pos_cmd_rx_in(bits[0]), .torque_mode_in(bits[1]),
    .speed_limit_in(bits[2]), .alarm_occurred_in(bits[3]), .alarm_clearable_in(bits[4]),
    .speed_mode_in(bits[5]), .speed_cmd_act_in(bits[6]), .output_select_first_in(osel[0]),
    .output_select_2_in(osel[1]), .output_select_3_in(osel[2]),
    .output_select_last_in(osel[3]), .speed_match_flag_out(fl[0]),
    .warning_out_a_out(fl[1]), .warning_out_b_out(fl[2]), .pos_cmd_active_out(fl[3]),
    .speed_clamp_out(fl[4]), .fault_clearable_flag_out(fl[5]),
    .speed_cmd_active_out(fl[6]), .terminal_out(term));
  status_host_model i_status_host_model (.clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .terminal_in(term), .seen_out(host_seen));
  always #50 ref_clk_in = ~ref_clk_in;
  // Flag i answers selection code i+1; code 0 leaves the terminal low
  function automatic logic [10:0] expect_of();
    int          d;
    logic [6:0]  f;
    logic [3:0]  t;
    // Plain integer error, independent of any narrow arithmetic
    d = int'(cmd) - int'(meas);
    if (d < 0) d = -d;
    f = {bits[5] | bits[6], bits[3] | bits[4], bits[1] | bits[2], bits[0],
         cond[sel_b], cond[sel_a], d <= int'(width)};
    for (int i = 0; i < 4; i++) t[i] = (osel[i] == 3'h0) ? 1'b0 : f[osel[i] - 3'h1];
    return {f, t};
  endfunction
  task automatic chk(input logic [10:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watcher: one note per driven cycle, checked after the edge settles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      stop_test();
    end else begin
      #1;
      // Host sees the terminals one edge late; reset clears its view
      if (!arst_n_in) host_exp = 4'h0;
      if (q.size() > 0) begin
        note = q.pop_front();
        chk(note);
        compares++;
        if (host_seen !== host_exp) begin
          n_fail++;
          $display("unexpected at %0t: host saw %h want %h", $time, host_seen, host_exp);
        end
        host_exp = note[3:0];
      end
    end
  end
  // Three cases in four sit on or just past the match window edge;
  // reset falls just after time zero so the flops see a real edge
  initial begin
    #1 arst_n_in = 1'b0;
    repeat (16) @(posedge ref_clk_in);
    #1 chk(11'h000);
    for (int n = 0; n < 800; n++) begin
      @(negedge ref_clk_in);
      if (n == 400) begin
        arst_n_in = 1'b0;
        #1 chk(11'h000);
        @(negedge ref_clk_in);
      end
      arst_n_in = 1'b1;
      width = 16'($random(seed)) & 16'h01FF;
      cmd   = 16'($random(seed));
      case (n % 4)
        0: meas = cmd - width;
        1: meas = cmd + width;
        2: meas = cmd - width - 16'h0001;
        default: meas = 16'($random(seed));
      endcase
      cond  = 16'($random(seed));
      sel_a = 4'($random(seed));
      sel_b = 4'($random(seed));
      bits  = 7'($random(seed));
      for (int i = 0; i < 4; i++) osel[i] = 3'($random(seed));
      q.push_back(expect_of());
    end
    @(negedge ref_clk_in);
    stop_test();
  end
endmodule
`default_nettype wire

// ### testbench/status_host_model.sv
/*
  Host model: samples the four status terminals once per cycle.
  Assumes terminal levels are settled at the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module status_host_model (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [3:0] terminal_in,
  output logic [3:0]      seen_out
);
  // A host only sees levels; edges between samples are lost
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) seen_out <= 4'h0;
    else seen_out <= terminal_in;
  end
endmodule
`default_nettype wire
